/* File: verilog/fepp_pkg.sv */
// package: constants and carrier types of the flash erase/program/protect sequencer
// What this block does
// - page erase sets all bits of the 128-byte page chosen by the dummy write
// - after a control write clears high voltage, reads resume after about 1us recovery
// - program rows are 64 aligned bytes; low six address bits pick the byte
// - program select latches address and data; protect read, dummy write, waits
// - sequence steps keep their order; unrelated bus traffic may come between
// - high voltage refused when the target lies in the protected range
// - protect byte zeros protects everything; all ones protects nothing
// - protect start is bit15 one, protect byte as bits 14:7, bits 6:0 zero
// - non-ones protect byte blocks changes there unless test high voltage present
// - protect byte is a flash byte, kept over reset, changed only by sequences
// - wait or stop during an operation aborts it into standby
// - wait or stop in read mode leaves flash state unchanged
// - erase and program select interlocked; voltage needs a bit and the sequence
// - erased bits read one, programmed bits read zero
`default_nettype none
package fepp_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // register indices on the plain port
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_PROT   = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_ALO    = 4'h3;
  localparam logic [3:0] ADDR_AHI    = 4'h4;
  localparam logic [3:0] ADDR_DATA   = 4'h5;
  // control field positions
  localparam int unsigned BIT_PGM  = 0;
  localparam int unsigned BIT_ERS  = 1;
  localparam int unsigned BIT_MASS = 2;
  localparam int unsigned BIT_HV   = 3;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  // protect byte: erased value and the 0x8000 base
  localparam logic [7:0]  PROT_OPEN = 8'hFF;
  localparam logic [7:0]  PROT_ALL  = 8'h00;
  localparam logic [7:0]  ERASED    = 8'hFF;
  localparam logic [15:0] FLASH_LO  = 16'h8000;
  localparam logic [15:0] PROT_LOC  = 16'hFF7E;
  localparam int unsigned PAGE_LSB  = 7;
  localparam int unsigned ROW_LSB   = 6;
  // recovery time after high voltage falls
  localparam int unsigned RCV_NS    = 1000;
  localparam int unsigned RCV_CYC   = (RCV_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  RCV_CNT   = 8'(RCV_CYC);

  typedef enum logic [2:0] {
    FEPP_IDLE, FEPP_ARMED, FEPP_LATCHED, FEPP_ACTIVE, FEPP_RECOVER
  } fepp_state_t;

  // request from the sequencer to the array
  typedef struct packed {
    logic        write;
    logic        pageErase;
    logic        massErase;
    logic [15:0] addr;
    logic [7:0]  data;
  } fepp_arr_req_t;
endpackage
`default_nettype wire

/* File: verilog/fepp_prot_check.sv */
// module: protect-range decode for one target address
`timescale 1ns/1ps
`default_nettype none
module fepp_prot_check (
  input  wire logic [7:0]  protByte,
  input  wire logic [15:0] target,
  input  wire logic        mass,
  input  wire logic        testHv,
  output logic             blocked
);
  logic [15:0] startAddr;
  // start address built from the protect byte
  assign startAddr = {1'b1, protByte, 7'h00};
  // all ones opens everything; mass touches the protected block if any exists
  always_comb begin
    if (testHv || protByte == fepp_pkg::PROT_OPEN) begin
      blocked = 1'b0;
    end else if (mass || protByte == fepp_pkg::PROT_ALL) begin
      blocked = 1'b1;
    end else begin
      blocked = (target >= startAddr);
    end
  end
endmodule
`default_nettype wire

/* File: verilog/fepp_array.sv */
// module: flash array model with page, mass and byte program operations
`timescale 1ns/1ps
`default_nettype none
module fepp_array #(
  parameter int unsigned DEPTH = 32768
) (
  input  wire logic                   ref_clk,
  input  wire fepp_pkg::fepp_arr_req_t req,
  input  wire logic [15:0]            rdAddr,
  output logic [7:0]                  rdData,
  output logic [7:0]                  protByte
);
  // no reset: contents survive reset like real flash
  logic [7:0] mem [DEPTH];
  logic [14:0] wIdx;
  assign wIdx = req.addr[14:0];
  assign protByte = mem[fepp_pkg::PROT_LOC[14:0]];
  assign rdData = mem[rdAddr[14:0]];

  // programming only clears bits; erase sets them to one
  // the sweep runs only on an erase cycle, so idle cycles stay cheap
  always_ff @(posedge ref_clk) begin
    if (req.massErase || req.pageErase) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (req.massErase) begin
          mem[i] <= fepp_pkg::ERASED;
        end else if (i[14:7] == wIdx[14:7]) begin
          mem[i] <= fepp_pkg::ERASED;
        end
      end
    end
    if (req.write) begin
      mem[wIdx] <= mem[wIdx] & req.data;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/fepp_top.sv */
// module: flash control sequencer with protection and standby abort
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fepp_top (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [7:0]       regRdata,
  input  wire logic        flashWr,
  input  wire logic [15:0] flashAddr,
  input  wire logic [7:0]  flashWdata,
  input  wire logic        cpuLowPower,
  input  wire logic        test_high_voltage,
  output logic             high_voltage_enable,
  output logic             standby,
  output logic             readReady
);
  typedef struct packed {
    fepp_pkg::fepp_state_t st;
    logic        program_select;
    logic        erase;
    logic        mass;
    logic        hv;
    logic        protRead;
    logic        refused;
    logic        standby;
    logic        readReady;
    logic [15:0] tgt;
    logic [15:0] lastAddr;
    logic [7:0]  lastData;
    logic [7:0]  rcv;
    logic [7:0]  rdata;
    logic [2:0]  tvSync;
    logic        tv;
    logic [2:0]  lpSync;
    logic        lp;
  } fepp_state_s_t;

  fepp_state_s_t s_r, s_nxt;
  fepp_pkg::fepp_arr_req_t req;
  logic [7:0]  protByte;
  logic [7:0]  arrData;
  logic        blocked;

  fepp_array u_array (
    .ref_clk  (ref_clk),
    .req      (req),
    .rdAddr   (s_r.lastAddr),
    .rdData   (arrData),
    .protByte (protByte)
  );

  fepp_prot_check u_prot (
    .protByte (protByte),
    .target   (s_r.tgt),
    .mass     (s_r.mass),
    .testHv   (s_r.tv),
    .blocked  (blocked)
  );

  function automatic logic inFlash(input logic [15:0] a);
    inFlash = (a >= fepp_pkg::FLASH_LO);
  endfunction

  // sequencer and register file next state
  always_comb begin
    s_nxt = s_r;
    req = '0;
    s_nxt.refused = 1'b0;
    // pins: three stages, accept once last two agree
    s_nxt.tvSync = {s_r.tvSync[1:0], test_high_voltage};
    if (s_r.tvSync[2] == s_r.tvSync[1]) s_nxt.tv = s_r.tvSync[2];
    s_nxt.lpSync = {s_r.lpSync[1:0], cpuLowPower};
    if (s_r.lpSync[2] == s_r.lpSync[1]) s_nxt.lp = s_r.lpSync[2];
    // reads: data in the following cycle only
    s_nxt.rdata = 8'h00;
    if (regRd) begin
      case (regAddr)
        fepp_pkg::ADDR_CTRL:   s_nxt.rdata = {4'h0, s_r.hv, s_r.mass, s_r.erase, s_r.program_select};
        fepp_pkg::ADDR_PROT: begin
          s_nxt.rdata = protByte;
          // reading the protect byte is a sequence step
          if ((s_r.erase || s_r.program_select) && !s_r.hv) s_nxt.protRead = 1'b1;
        end
        fepp_pkg::ADDR_STATUS: s_nxt.rdata = {3'h0, s_r.refused, s_r.readReady, s_r.standby, blocked,
                                              s_r.protRead};
        fepp_pkg::ADDR_ALO:    s_nxt.rdata = s_r.lastAddr[7:0];
        fepp_pkg::ADDR_AHI:    s_nxt.rdata = s_r.lastAddr[15:8];
        fepp_pkg::ADDR_DATA:   s_nxt.rdata = arrData;
        default:               s_nxt.rdata = 8'h00;
      endcase
    end
    // control writes
    if (regWr && regAddr == fepp_pkg::ADDR_CTRL) begin
      s_nxt.mass = regWdata[fepp_pkg::BIT_MASS];
      // interlock: a write setting both leaves selection unchanged
      if (!(regWdata[fepp_pkg::BIT_PGM] && regWdata[fepp_pkg::BIT_ERS]) &&
          !(regWdata[fepp_pkg::BIT_PGM] && s_r.erase) &&
          !(regWdata[fepp_pkg::BIT_ERS] && s_r.program_select)) begin
        s_nxt.program_select = regWdata[fepp_pkg::BIT_PGM];
        s_nxt.erase = regWdata[fepp_pkg::BIT_ERS];
      end
      if (regWdata[fepp_pkg::BIT_HV] && !s_r.hv) begin
        // only after select, protect read and dummy write, and not protected
        // a write that also drops the mode bits may not raise the voltage
        if (s_r.st == fepp_pkg::FEPP_LATCHED && s_r.protRead && !blocked &&
            (s_nxt.erase || s_nxt.program_select)) begin
          s_nxt.hv = 1'b1;
          s_nxt.st = fepp_pkg::FEPP_ACTIVE;
          s_nxt.standby = 1'b0;
        end else begin
          s_nxt.refused = 1'b1;
        end
      end else if (!regWdata[fepp_pkg::BIT_HV] && s_r.hv) begin
        // voltage falls: turn off the pump and start recovery; the erase commits when erase drops
        s_nxt.hv = 1'b0;
        s_nxt.st = fepp_pkg::FEPP_RECOVER;
        s_nxt.rcv = fepp_pkg::RCV_CNT;
        s_nxt.readReady = 1'b0;
      end
    end
    // sequence tracking on flash bus writes
    case (s_r.st)
      fepp_pkg::FEPP_IDLE: begin
        if (s_nxt.erase || s_nxt.program_select) s_nxt.st = fepp_pkg::FEPP_ARMED;
      end
      fepp_pkg::FEPP_ARMED: begin
        // other traffic between steps is tolerated
        if (flashWr && s_r.protRead && inFlash(flashAddr)) begin
          s_nxt.tgt = flashAddr;
          s_nxt.lastAddr = flashAddr;
          s_nxt.lastData = flashWdata;
          s_nxt.st = fepp_pkg::FEPP_LATCHED;
        end
      end
      fepp_pkg::FEPP_LATCHED: begin
        if (flashWr && inFlash(flashAddr)) begin
          s_nxt.tgt = flashAddr;
          s_nxt.lastAddr = flashAddr;
        end
      end
      fepp_pkg::FEPP_ACTIVE: begin
        // byte program within the latched row only
        if (s_r.program_select && flashWr && flashAddr[15:fepp_pkg::ROW_LSB] ==
            s_r.tgt[15:fepp_pkg::ROW_LSB]) begin
          req.write = 1'b1;
          req.addr = flashAddr;
          req.data = flashWdata;
          s_nxt.lastAddr = flashAddr;
          s_nxt.lastData = flashWdata;
        end
      end
      fepp_pkg::FEPP_RECOVER: begin
        if (s_r.rcv == 8'h00) begin
          s_nxt.readReady = 1'b1;
          s_nxt.st = fepp_pkg::FEPP_IDLE;
        end else begin
          s_nxt.rcv = s_r.rcv - 8'h01;
        end
      end
      default: s_nxt.st = fepp_pkg::FEPP_IDLE;
    endcase
    // erase applies while voltage is on and erase selected, once erase drops
    if (s_r.st == fepp_pkg::FEPP_ACTIVE && s_r.erase && !s_nxt.erase) begin
      req.pageErase = !s_r.mass;
      req.massErase = s_r.mass;
      req.addr = s_r.tgt;
    end
    if (!s_nxt.erase && !s_nxt.program_select && s_nxt.st != fepp_pkg::FEPP_ACTIVE &&
        s_nxt.st != fepp_pkg::FEPP_RECOVER) begin
      s_nxt.protRead = 1'b0;
      s_nxt.st = fepp_pkg::FEPP_IDLE;
    end
    // low power mid-operation aborts; in read mode nothing changes
    if (s_r.lp && s_r.st != fepp_pkg::FEPP_IDLE && s_r.st != fepp_pkg::FEPP_RECOVER) begin
      req = '0;
      s_nxt.program_select = 1'b0;
      s_nxt.erase = 1'b0;
      s_nxt.mass = 1'b0;
      s_nxt.hv = 1'b0;
      s_nxt.protRead = 1'b0;
      s_nxt.standby = 1'b1;
      s_nxt.st = fepp_pkg::FEPP_IDLE;
    end
  end

  // state register; array contents are untouched by reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.readReady <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign regRdata = s_r.rdata;
  assign high_voltage_enable = s_r.hv;
  assign standby = s_r.standby;
  assign readReady = s_r.readReady;
endmodule
`default_nettype wire

/* File: test/fepp_top_assertions.sv */
// checker: port-level assertions for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fepp_top_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       cpuLowPower,
  input wire logic       high_voltage_enable,
  input wire logic       standby,
  input wire logic       readReady
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // reset leaves the charge pump off and reads open
  AST_RESET_STATE: assert property (disable iff (1'b0)
    rst |=> !high_voltage_enable && !standby && readReady) else $error("bad state after reset");
  // read data only in the cycle after a read strobe
  AST_RDATA_ZERO: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data outside its cycle");
  // high voltage only follows a control write asking for it
  AST_HV_CAUSE: assert property ($rose(high_voltage_enable) |->
    $past(regWr && regAddr == fepp_pkg::ADDR_CTRL && regWdata[fepp_pkg::BIT_HV])) else $error("hv rose unasked");
  // exactly one of erase or program select beside it
  AST_HV_MODE: assert property ($rose(high_voltage_enable) |->
    $past(regWdata[fepp_pkg::BIT_PGM] != regWdata[fepp_pkg::BIT_ERS])) else $error("hv without one mode");
  // recovery starts when the pump turns off normally
  AST_RCV_LOW: assert property ($fell(high_voltage_enable) && !standby |-> ##[0:1] !readReady)
    else $error("no recovery after hv off");
  // recovery lasts about one microsecond
  AST_RCV_END: assert property ($fell(readReady) |-> ##[95:105] $rose(readReady))
    else $error("recovery length wrong");
  // low power during an operation aborts into standby; sync lag allowed
  AST_ABORT: assert property (cpuLowPower && high_voltage_enable |->
    ##[1:6] (!high_voltage_enable && standby)) else $error("no abort on low power");
  // standby never appears without low power
  AST_SB_CAUSE: assert property ($rose(standby) |-> $past(cpuLowPower))
    else $error("standby without low power");
endmodule
bind fepp_top fepp_top_checker chk_u (.ref_clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
  .cpuLowPower, .high_voltage_enable, .standby, .readReady);
`default_nettype wire

/* File: test/fepp_cpu_model.sv */
// model: processor routine driving the flash control port
`timescale 1ns/1ps
`default_nettype none
module fepp_cpu_model (
  input  wire logic        ref_clk,
  input  wire logic [7:0]  regRdata,
  output logic [3:0]       regAddr,
  output logic [7:0]       regWdata,
  output logic             regWr,
  output logic             regRd,
  output logic             flashWr,
  output logic [15:0]      flashAddr,
  output logic [7:0]       flashWdata
);
  // waits shortened to keep the run short; the device does not time them
  localparam int NVS_NS = 200;
  localparam int NVS    = int'((NVS_NS * fepp_pkg::CLK_MHZ + 999) / 1000);
  initial begin
    {regAddr, regWdata, regWr, regRd, flashWr, flashAddr, flashWdata} = '0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    // data stands in the cycle after the strobe; taken at its closing edge
    @(posedge ref_clk);
    d = regRdata;
  endtask
  // write into flash space; the routine lives here, never fetched from flash
  task automatic fw(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    flashAddr <= a;
    flashWdata <= d;
    flashWr <= 1'b1;
    @(posedge ref_clk);
    flashWr <= 1'b0;
    repeat (NVS) @(posedge ref_clk);
  endtask
  // mode bits, protect read, dummy write, then ask for high voltage
  task automatic arm(input logic [7:0] mode, input logic [15:0] a);
    logic [7:0] p;
    wr(fepp_pkg::ADDR_CTRL, mode);
    rd(fepp_pkg::ADDR_PROT, p);
    fw(a, 8'h00);
    wr(fepp_pkg::ADDR_CTRL, mode | 8'h08);
  endtask
  // drop mode bits, then voltage, then sit out recovery
  task automatic close();
    wr(fepp_pkg::ADDR_CTRL, 8'h08);
    repeat (NVS) @(posedge ref_clk);
    wr(fepp_pkg::ADDR_CTRL, 8'h00);
    repeat (fepp_pkg::RCV_CYC + 20) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* File: test/tb_flash_erase_program_protect.sv */
// testbench: erase, program, protection and abort sequences
`timescale 1ns/1ps
`default_nettype none
module tb_flash_erase_program_protect;
  logic        ref_clk, rst, regWr, regRd, flashWr, cpuLowPower, test_high_voltage;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata, flashWdata, d;
  logic [15:0] flashAddr;
  logic        high_voltage_enable, standby, readReady;
  int          bad_count = 0;
  int          comparisons = 0;
  fepp_cpu_model cpu_u (.ref_clk, .regRdata, .regAddr, .regWdata, .regWr, .regRd, .flashWr, .flashAddr,
    .flashWdata);
  fepp_top dut_u (.ref_clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .flashWr, .flashAddr,
    .flashWdata, .cpuLowPower, .test_high_voltage, .high_voltage_enable, .standby, .readReady);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    cpu_u.rd(a, d);
    chk(d, exp);
  endtask
  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    complete_run();
  end
  initial begin
    {rst, cpuLowPower, test_high_voltage} = 3'b101;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk({5'h00, high_voltage_enable, standby, readReady}, 8'h01);
    rchk(fepp_pkg::ADDR_CTRL, fepp_pkg::CTRL_RST);
    rchk(4'hF, 8'h00);
    // mass erase under test voltage gives known contents; dummy write on the protect byte
    cpu_u.arm(8'h06, fepp_pkg::PROT_LOC);
    #1 chk({7'h00, high_voltage_enable}, 8'h01);
    cpu_u.close();
    rchk(fepp_pkg::ADDR_PROT, fepp_pkg::PROT_OPEN);
    rchk(fepp_pkg::ADDR_DATA, fepp_pkg::ERASED);
    @(posedge ref_clk) test_high_voltage <= 1'b0;
    // program one byte of the erased row, then page erase it back to ones
    cpu_u.arm(8'h01, 16'h8000);
    cpu_u.fw(16'h8000, 8'h5A);
    cpu_u.close();
    rchk(fepp_pkg::ADDR_DATA, 8'h5A);
    cpu_u.arm(8'h02, 16'h8000);
    #1 chk({7'h00, high_voltage_enable}, 8'h01);
    cpu_u.close();
    rchk(fepp_pkg::ADDR_DATA, fepp_pkg::ERASED);
    // protect from 0x8080 upward
    cpu_u.arm(8'h01, 16'hFF40);
    cpu_u.fw(fepp_pkg::PROT_LOC, 8'h01);
    cpu_u.close();
    rchk(fepp_pkg::ADDR_PROT, 8'h01);
    rchk(fepp_pkg::ADDR_ALO, fepp_pkg::PROT_LOC[7:0]);
    rchk(fepp_pkg::ADDR_AHI, fepp_pkg::PROT_LOC[15:8]);
    cpu_u.arm(8'h02, 16'h8080);
    #1 chk({7'h00, high_voltage_enable}, 8'h00);
    rchk(fepp_pkg::ADDR_STATUS, 8'h0B);
    cpu_u.close();
    cpu_u.arm(8'h02, 16'h807F);
    #1 chk({7'h00, high_voltage_enable}, 8'h01);
    cpu_u.close();
    // both modes at once, and voltage without a mode
    cpu_u.wr(fepp_pkg::ADDR_CTRL, 8'h03);
    rchk(fepp_pkg::ADDR_CTRL, 8'h00);
    cpu_u.wr(fepp_pkg::ADDR_CTRL, 8'h08);
    #1 chk({7'h00, high_voltage_enable}, 8'h00);
    // low power in read mode, held past the pin filter, changes nothing
    @(posedge ref_clk) cpuLowPower <= 1'b1;
    repeat (8) @(posedge ref_clk);
    cpuLowPower <= 1'b0;
    #1 chk({6'h00, standby, readReady}, 8'h01);
    repeat (4) @(posedge ref_clk);
    rchk(fepp_pkg::ADDR_CTRL, 8'h00);
    // low power mid-program aborts into standby
    cpu_u.arm(8'h01, 16'h8000);
    #1 chk({7'h00, high_voltage_enable}, 8'h01);
    @(posedge ref_clk) cpuLowPower <= 1'b1;
    for (int i = 0; i < 8 && standby !== 1'b1; i++) @(posedge ref_clk);
    #1 chk({6'h00, high_voltage_enable, standby}, 8'h01);
    @(posedge ref_clk) cpuLowPower <= 1'b0;
    rchk(fepp_pkg::ADDR_CTRL, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
